//--- design/rtac_top.sv
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
// Register-to-accumulator transfer unit with an AXI4-Lite register port
module rtac_top (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [3:0]                 accumulator,
	output logic                       carry_flag
);

	rtac_dec_if dif ();

	rtac_pkg::rtac_addr_t  aw_addr_q;
	logic                  aw_have_q;
	rtac_pkg::rtac_data_t  w_data_q;
	logic [3:0]            w_strb_q;
	logic                  w_have_q;
	logic                  awready_q;
	logic                  wready_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  arready_q;
	logic                  rvalid_q;
	logic [1:0]            rresp_q;
	rtac_pkg::rtac_data_t  rdata_q;
	rtac_pkg::rtac_instr_t instr_q;
	logic                  exec_q;
	rtac_pkg::rtac_nib_t   acc_q;
	logic                  carry_q;
	logic                  hit_q;
	logic                  miss_q;
	rtac_pkg::rtac_nib_t   src_q [rtac_pkg::SRC_N];
	logic [rtac_pkg::SRC_N-1:0] src_hit_w;
	logic [rtac_pkg::SRC_N-1:0] src_hit_r;
	logic                  do_write;
	logic                  do_read;
	logic                  wr_instr;
	logic                  wr_acc;
	logic                  wr_carry;
	rtac_pkg::rtac_addr_t  wa_word;
	rtac_pkg::rtac_addr_t  ra_word;
	logic                  wa_known;
	logic                  ra_known;
	rtac_pkg::rtac_data_t  rd_mux;

	// Both halves of a write present and no answer outstanding
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign do_read  = s_axi_arvalid && arready_q;
	assign wa_word  = aw_addr_q & rtac_pkg::ADDR_WORD_MASK;
	assign ra_word  = s_axi_araddr & rtac_pkg::ADDR_WORD_MASK;

	// Per-register write strobes, decoded once for every writer
	assign wr_instr = do_write && (wa_word == rtac_pkg::ADDR_INSTR) && (&w_strb_q[1:0]);
	assign wr_acc   = do_write && (wa_word == rtac_pkg::ADDR_ACC) && w_strb_q[0];
	assign wr_carry = do_write && (wa_word == rtac_pkg::ADDR_CARRY) && w_strb_q[0];

	// Write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_q <= '0;
		end else if (s_axi_awvalid && awready_q) begin
			aw_addr_q <= s_axi_awaddr;
		end
	end

	// Address held until the write is carried out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
		end else if (s_axi_awvalid && awready_q) begin
			aw_have_q <= 1'b1;
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	// Address ready drops until the response is taken; one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
		end else if (s_axi_awvalid && awready_q) begin
			awready_q <= 1'b0;
		end else if (bvalid_q && s_axi_bready) begin
			awready_q <= 1'b1;
		end
	end

	// Write data capture, may arrive before or after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (s_axi_wvalid && wready_q) begin
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	// Data held until the write is carried out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
		end else if (s_axi_wvalid && wready_q) begin
			w_have_q <= 1'b1;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	// Data ready mirrors address ready so no second beat slips in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_q <= 1'b1;
		end else if (s_axi_wvalid && wready_q) begin
			wready_q <= 1'b0;
		end else if (bvalid_q && s_axi_bready) begin
			wready_q <= 1'b1;
		end
	end

	// Per-source address match, one write and one read comparator per slot
	for (genvar g = 0; g < rtac_pkg::SRC_N; g++) begin : g_src
		localparam rtac_pkg::rtac_addr_t SRC_ADDR =
			rtac_pkg::rtac_addr_t'(rtac_pkg::ADDR_SRC_BASE + g * rtac_pkg::ADDR_STRIDE);

		assign src_hit_w[g] = (wa_word == SRC_ADDR);
		assign src_hit_r[g] = (ra_word == SRC_ADDR);

		// Only software writes change a source; execution merely samples it
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				src_q[g] <= rtac_pkg::SRC_RST;
			end else if (do_write && src_hit_w[g] && w_strb_q[0]) begin
				src_q[g] <= w_data_q[rtac_pkg::NIB_W-1:0] & rtac_pkg::SRC_MASK[g];
			end
		end

		assign dif.src[g] = src_q[g];
	end

	assign wa_known = (wa_word == rtac_pkg::ADDR_INSTR) || (wa_word == rtac_pkg::ADDR_ACC) ||
			(wa_word == rtac_pkg::ADDR_CARRY) || (wa_word == rtac_pkg::ADDR_STATUS) ||
			(|src_hit_w);
	assign ra_known = (ra_word == rtac_pkg::ADDR_INSTR) || (ra_word == rtac_pkg::ADDR_ACC) ||
			(ra_word == rtac_pkg::ADDR_CARRY) || (ra_word == rtac_pkg::ADDR_STATUS) ||
			(|src_hit_r);

	// Write response stands until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Unmapped addresses answer decode error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bresp_q <= rtac_pkg::RESP_OKAY;
		end else if (do_write) begin
			bresp_q <= wa_known ? rtac_pkg::RESP_OKAY : rtac_pkg::RESP_DECERR;
		end
	end

	// Instruction word; a write with both low lanes present issues it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_q <= rtac_pkg::INSTR_RST;
		end else if (wr_instr) begin
			instr_q <= w_data_q[rtac_pkg::INSTR_W-1:0];
		end
	end

	// Execute slot, one cycle after the word lands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exec_q <= 1'b0;
		end else begin
			exec_q <= wr_instr;
		end
	end

	assign dif.instr = instr_q;

	rtac_decode u_decode (
		.dif (dif.dec)
	);

	// Accumulator: one-cycle transfer on a decoded hit, else software load
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= rtac_pkg::ACC_RST;
		end else if (exec_q && dif.hit) begin
			acc_q <= dif.data;
		end else if (wr_acc) begin
			acc_q <= w_data_q[rtac_pkg::NIB_W-1:0];
		end
	end

	// Carry only moves under software; transfers leave it alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			carry_q <= rtac_pkg::CARRY_RST;
		end else if (wr_carry) begin
			carry_q <= w_data_q[0];
		end
	end

	// Last issued word matched a transfer opcode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hit_q <= 1'b0;
		end else if (exec_q) begin
			hit_q <= dif.hit;
		end
	end

	// Last issued word was unknown; the accumulator kept its value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			miss_q <= 1'b0;
		end else if (exec_q) begin
			miss_q <= !dif.hit;
		end
	end

	// Read data selection
	always_comb begin
		rd_mux = '0;
		if (ra_word == rtac_pkg::ADDR_INSTR) begin
			rd_mux[rtac_pkg::INSTR_W-1:0] = instr_q;
		end else if (ra_word == rtac_pkg::ADDR_ACC) begin
			rd_mux[rtac_pkg::NIB_W-1:0] = acc_q;
		end else if (ra_word == rtac_pkg::ADDR_CARRY) begin
			rd_mux[0] = carry_q;
		end else if (ra_word == rtac_pkg::ADDR_STATUS) begin
			rd_mux[rtac_pkg::STAT_HIT_BIT]  = hit_q;
			rd_mux[rtac_pkg::STAT_MISS_BIT] = miss_q;
			rd_mux[rtac_pkg::STAT_BUSY_BIT] = exec_q;
		end else begin
			for (int i = 0; i < rtac_pkg::SRC_N; i++) begin
				if (src_hit_r[i]) begin
					rd_mux[rtac_pkg::NIB_W-1:0] = src_q[i];
				end
			end
		end
	end

	// Read address ready low while an answer is outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
		end else if (do_read) begin
			arready_q <= 1'b0;
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
		end else if (do_read) begin
			rvalid_q <= 1'b1;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Read payload latched at the take, so it stands unchanged with valid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_q <= '0;
			rresp_q <= rtac_pkg::RESP_OKAY;
		end else if (do_read) begin
			rdata_q <= ra_known ? rd_mux : '0;
			rresp_q <= ra_known ? rtac_pkg::RESP_OKAY : rtac_pkg::RESP_DECERR;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign accumulator   = acc_q;
	assign carry_flag    = carry_q;

endmodule : rtac_top

//--- design/rtac_pkg.sv
// What this block does
// - Clock-control read opcode loads all four clock control bits into accumulator, carry kept.
// - Opcode 257h copies pull-up control 0 into accumulator, one cycle, carry kept.
// - Opcode 25Eh copies pull-up control 1 into accumulator, one cycle, carry kept.
// - Opcode 25Fh copies pull-up control 2 into accumulator, one cycle, carry kept.
// - Opcode 050h puts stack pointer in accumulator bits 2..0, bit 3 cleared.
// - Opcode 054h copies interrupt control one into accumulator, one cycle, carry kept.
// - Opcode 055h copies interrupt control two into accumulator, one cycle, carry kept.
// - Opcode 24Bh copies timer control one into accumulator, one cycle, carry kept.
package rtac_pkg;

	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned INSTR_W = 10;
	localparam int unsigned NIB_W   = 4;
	localparam int unsigned SRC_N   = 8;

	typedef logic [ADDR_W-1:0]  rtac_addr_t;
	typedef logic [DATA_W-1:0]  rtac_data_t;
	typedef logic [INSTR_W-1:0] rtac_instr_t;
	typedef logic [NIB_W-1:0]   rtac_nib_t;
	typedef logic [2:0]         rtac_sel_t;

	// Source slots, in register-map order
	localparam int unsigned SRC_CLOCK  = 0;
	localparam int unsigned SRC_PULL0  = 1;
	localparam int unsigned SRC_PULL1  = 2;
	localparam int unsigned SRC_PULL2  = 3;
	localparam int unsigned SRC_STACK  = 4;
	localparam int unsigned SRC_IRQ1   = 5;
	localparam int unsigned SRC_IRQ2   = 6;
	localparam int unsigned SRC_TIMER1 = 7;

	// Instruction words
	localparam rtac_instr_t OP_READ_CLOCK_CTL     = 10'h252;
	localparam rtac_instr_t OP_READ_PULLUP_CTL_0  = 10'h257;
	localparam rtac_instr_t OP_READ_PULLUP_CTL_1  = 10'h25E;
	localparam rtac_instr_t OP_READ_PULLUP_CTL_2  = 10'h25F;
	localparam rtac_instr_t OP_READ_STACK_PTR     = 10'h050;
	localparam rtac_instr_t OP_READ_IRQ_CTL_ONE   = 10'h054;
	localparam rtac_instr_t OP_READ_IRQ_CTL_TWO   = 10'h055;
	localparam rtac_instr_t OP_READ_TIMER_CTL_ONE = 10'h24B;

	localparam rtac_instr_t SRC_OPCODE [SRC_N] = '{
		OP_READ_CLOCK_CTL, OP_READ_PULLUP_CTL_0, OP_READ_PULLUP_CTL_1,
		OP_READ_PULLUP_CTL_2, OP_READ_STACK_PTR, OP_READ_IRQ_CTL_ONE,
		OP_READ_IRQ_CTL_TWO, OP_READ_TIMER_CTL_ONE};

	// Implemented bits per source; the stack pointer is three bits wide
	localparam rtac_nib_t SRC_MASK [SRC_N] = '{
		4'hF, 4'hF, 4'hF, 4'hF, 4'h7, 4'hF, 4'hF, 4'hF};

	// Register map, byte addresses
	localparam rtac_addr_t ADDR_INSTR     = 8'h00;
	localparam rtac_addr_t ADDR_ACC       = 8'h04;
	localparam rtac_addr_t ADDR_CARRY     = 8'h08;
	localparam rtac_addr_t ADDR_STATUS    = 8'h0C;
	localparam rtac_addr_t ADDR_SRC_BASE  = 8'h10;
	localparam int unsigned ADDR_STRIDE   = 4;
	localparam rtac_addr_t ADDR_WORD_MASK = 8'hFC;

	// Status fields
	localparam int unsigned STAT_HIT_BIT  = 0;
	localparam int unsigned STAT_MISS_BIT = 1;
	localparam int unsigned STAT_BUSY_BIT = 2;

	// Reset values
	localparam rtac_instr_t INSTR_RST = 10'h000;
	localparam rtac_nib_t   ACC_RST   = 4'h0;
	localparam rtac_nib_t   SRC_RST   = 4'h0;
	localparam logic        CARRY_RST = 1'b0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : rtac_pkg

//--- design/rtac_dec_if.sv
`timescale 1ns/100ps
// Link between the register file and the instruction decoder
interface rtac_dec_if;
	rtac_pkg::rtac_instr_t instr;
	rtac_pkg::rtac_nib_t   src [rtac_pkg::SRC_N];
	logic                  hit;
	rtac_pkg::rtac_nib_t   data;

	modport regs (output instr, output src, input hit, input data);
	modport dec (input instr, input src, output hit, output data);
endinterface : rtac_dec_if

//--- design/rtac_decode.sv
`timescale 1ns/100ps
// Pure combinational decode; never writes a source, so reads have no side effect
module rtac_decode (
	rtac_dec_if.dec dif
);

	// Full ten-bit compare against each opcode
	always_comb begin
		dif.hit  = 1'b0;
		dif.data = rtac_pkg::ACC_RST;
		for (int i = 0; i < rtac_pkg::SRC_N; i++) begin
			if (dif.instr == rtac_pkg::SRC_OPCODE[i]) begin
				dif.hit  = 1'b1;
				// Mask clears bit 3 for the stack pointer
				dif.data = dif.src[i] & rtac_pkg::SRC_MASK[i];
			end
		end
	end

endmodule : rtac_decode

//--- tb/rtac_checker.sv
`timescale 1ns/100ps
// Port-level watcher of the transfer unit
module rtac_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic [3:0]  accumulator,
	input wire logic        carry_flag
);
	logic [7:0] wa_q;
	logic [7:0] ra_q;
	logic [9:0] wd_q;
	logic       bv_q;
	logic       ex_q;
	logic       bnew;
	logic [3:0] sh_q [8];
	logic       pu_hit;
	logic       it_hit;
	logic       cs_hit;
	logic [3:0] xval;
	// First response cycle, which is also the execute slot; the cycle after it shows the result
	assign bnew = s_axi_bvalid && !bv_q;
	// Last accepted address and data, held well past the response
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[9:0];
		if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
	end
	// Edge history; cleared by reset so no stale slot survives it
	always_ff @(posedge aclk) begin
		bv_q <= aresetn && s_axi_bvalid;
		ex_q <= aresetn && bnew;
	end
	// Shadow of the source registers, built from accepted writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 8; i++) sh_q[i] <= 4'h0;
		end else if (bnew && wa_q[7:2] >= 6'h04 && wa_q[7:2] <= 6'h0B) begin
			sh_q[3'(wa_q[7:2] - 6'h04)] <= wd_q[3:0];
		end
	end
	// Expected transfer result in the cycle after the execute slot, per opcode group
	always_comb begin
		pu_hit = 1'b0;
		it_hit = 1'b0;
		cs_hit = 1'b0;
		xval   = 4'h0;
		for (int unsigned i = 0; i < rtac_pkg::SRC_N; i++) begin
			if (ex_q && wa_q[7:2] == 6'h00 && wd_q == rtac_pkg::SRC_OPCODE[i]) begin
				xval   = sh_q[i] & rtac_pkg::SRC_MASK[i];
				pu_hit = (i >= rtac_pkg::SRC_PULL0) && (i <= rtac_pkg::SRC_PULL2);
				it_hit = (i >= rtac_pkg::SRC_IRQ1);
				cs_hit = (i == rtac_pkg::SRC_CLOCK) || (i == rtac_pkg::SRC_STACK);
			end
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_carry_sw_only: assert property ($changed(carry_flag) |-> bnew && wa_q[7:2] == 6'h02)
		else $error("carry moved without a carry write");
	a_acc_cause: assert property ($changed(accumulator) |->
		(bnew && wa_q[7:2] == 6'h01) || (ex_q && wa_q[7:2] == 6'h00))
		else $error("accumulator moved without a cause");
	a_stack_top_clear: assert property (bnew && wa_q[7:2] == 6'h00 && wd_q == 10'h050
		|=> !accumulator[3]) else $error("stack read left bit 3 set");
	a_unknown_keep: assert property (bnew && wa_q[7:2] == 6'h00 && wd_q[9:8] == 2'h3
		|=> $stable(accumulator)) else $error("unknown word moved accumulator");
	a_wr_unmapped: assert property (bnew && wa_q >= 8'h30 |-> s_axi_bresp == 2'h3)
		else $error("unmapped write not refused");
	a_rd_unmapped: assert property ($rose(s_axi_rvalid) && ra_q >= 8'h30 |->
		s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("unmapped read bad");
	a_rd_one_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_wr_two_cycle: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_pullup_copy: assert property (pu_hit |-> accumulator == xval)
		else $error("pull-up transfer loaded wrong value");
	a_irq_timer_copy: assert property (it_hit |-> accumulator == xval)
		else $error("interrupt or timer transfer loaded wrong value");
	a_ctl_stack_copy: assert property (cs_hit |-> accumulator == xval)
		else $error("clock or stack transfer loaded wrong value");
	c_exec: cover property (ex_q && wa_q[7:2] == 6'h00);
	c_unmapped: cover property ($rose(s_axi_rvalid) && ra_q >= 8'h30);
	c_carry: cover property ($changed(carry_flag));
endmodule : rtac_checker

bind rtac_top rtac_checker chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .accumulator(accumulator),
	.carry_flag(carry_flag));

//--- tb/rtac_tb_top.sv
`timescale 1ns/100ps
module register_to_acc_transfer_decode_tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  aw = 8'h00;
	logic [7:0]  ar = 8'h00;
	logic [31:0] wd = 32'h0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        arv = 1'b0;
	logic        rdy = 1'b1;
	logic        awr, wr_r, bv, arr, rv, cy;
	logic [1:0]  br, rr;
	logic [31:0] rdat;
	logic [3:0]  acc;
	int          fail_count = 0;
	int          n_compared = 0;
	int          src_m [8] = '{default: 0};
	int          acc_m = 0;
	logic [9:0]  ops [8] = '{10'h252, 10'h257, 10'h25E, 10'h25F, 10'h050, 10'h054, 10'h055, 10'h24B};

	// Response ready held high: every answer is taken at once
	rtac_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(rdy),
		.s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rdy), .accumulator(acc),
		.carry_flag(cy));

	always #10 aclk = ~aclk;

	task automatic give_verdict;
		if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (n = 0; n < 100 && !(n > 0 && bv); n++) begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end
		if (bv !== 1'b1) begin
			fail_count++;
			give_verdict();
		end
		chk({30'h0, br}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		ar <= a;
		arv <= 1'b1;
		for (n = 0; n < 100 && !(n > 0 && rv); n++) begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end
		if (rv !== 1'b1) begin
			fail_count++;
			give_verdict();
		end
		chk(rdat, exp);
		chk({30'h0, rr}, {30'h0, er});
	endtask : rd

	// Issue a word, then let the execute slot land before looking
	task automatic run(input logic [9:0] op);
		wr(8'h00, {22'h0, op}, 2'h0);
		@(posedge aclk);
		chk({28'h0, acc}, 32'(acc_m));
		chk({31'h0, cy}, 32'h1);
	endtask : run

	initial begin
		int i, k, j, v;
		logic [9:0] f;
		v = $urandom(32'hB35E);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 12; i++) rd(8'(i * 4), 32'h0, 2'h0);
		rd(8'h30, 32'h0, 2'h3);
		wr(8'h30, 32'hF, 2'h3);
		wr(8'h08, 32'h1, 2'h0);
		// Software accumulator load, the path a transfer must not disturb
		wr(8'h04, 32'hA, 2'h0);
		chk({28'h0, acc}, 32'hA);
		rd(8'h04, 32'hA, 2'h0);
		// Second pass uses all-ones to hit the stack pointer width limit
		for (k = 0; k < 2; k++) begin
			for (i = 0; i < 8; i++) begin
				v = k ? 15 : int'($urandom % 16);
				wr(8'(16 + i * 4), 32'(v), 2'h0);
				src_m[i] = (i == 4) ? (v & 7) : v;
				acc_m = src_m[i];
				run(ops[i]);
				rd(8'(16 + i * 4), 32'(src_m[i]), 2'h0);
				rd(8'h0C, 32'h1, 2'h0);
				f = ops[i] ^ 10'(1 << ((k * 8 + i) % 10));
				v = 2;
				for (j = 0; j < 8; j++) begin
					if (f == ops[j]) acc_m = src_m[j];
					if (f == ops[j]) v = 1;
				end
				run(f);
				rd(8'h0C, 32'(v), 2'h0);
			end
		end
		give_verdict();
	end
endmodule : register_to_acc_transfer_decode_tb_top
